// [hdl/ide_regs.vh]
// Constants for the input deserializer: encodings, offsets, fields, resets
`ifndef IDE_REGS_VH
`define IDE_REGS_VH

// ****************************************************************
// Configuration encodings
// ****************************************************************
`define IDE_RATE_SDR          0
`define IDE_RATE_DDR          1
`define IDE_MODEL_MEMORY      0
`define IDE_MODEL_DDR3        1
`define IDE_MODEL_QUAD        2
`define IDE_MODEL_FOUR_PHASE  3
`define IDE_MODEL_STREAM      4
`define IDE_ROUTE_NONE        0
`define IDE_ROUTE_COMB        1
`define IDE_ROUTE_REG         2
`define IDE_ROUTE_BOTH        3
`define IDE_ROLE_PRIMARY      0
`define IDE_ROLE_SECONDARY    1
`define IDE_LOCAL_MAX         8

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define IDE_OFF_CTRL          8'h00
`define IDE_OFF_STATUS        8'h04
`define IDE_OFF_WORD_COUNT    8'h08
`define IDE_OFF_CONFIG        8'h0c
`define IDE_CTRL_FAST_SEL     0
`define IDE_CTRL_SLOW_SEL     1
`define IDE_CTRL_RESET        2'h0
`define IDE_STAT_COMB_LSB     8
`define IDE_STAT_EN_BIT       12
`define IDE_CFG_RATE_BIT      4
`define IDE_CFG_MODEL_LSB     5
`define IDE_CFG_NUMCE_BIT     8
`define IDE_CFG_LOOP_BIT      9
`define IDE_CFG_ROLE_BIT      10
`define IDE_CFG_ROUTE_LSB     11
`define IDE_RESP_OKAY         2'h0
`define IDE_RESP_SLVERR       2'h2

`endif

// [hdl/ide_divider.v]
// Divided-clock enable generator with selectable half-period phase
module ide_divider #(
    parameter PERIOD = 2
) (
    input  wire i_mclk,
    input  wire i_reset_n,
    input  wire i_invert,
    output wire o_tick,
    output wire o_first_half
);

    localparam [31:0] LAST_W = PERIOD - 1;
    localparam [31:0] HALF_W = PERIOD / 2;
    localparam [3:0]  LAST   = LAST_W[3:0];
    localparam [3:0]  HALF   = HALF_W[3:0];

    reg  [3:0] cnt_q;
    wire [3:0] cnt_d;

    // Free-running count of fast cycles within one divided cycle
    assign cnt_d = (cnt_q == LAST) ? 4'h0 : cnt_q + 4'h1;

    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            cnt_q <= 4'h0; // Restarts aligned to the first edge after reset
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Inverted polarity moves the word boundary by half a period
    assign o_tick       = i_invert ? (cnt_q == HALF - 4'h1) : (cnt_q == LAST);
    assign o_first_half = i_invert ? (cnt_q >= HALF) : (cnt_q < HALF);

endmodule

// [hdl/ide_deserializer.v]
// Input serial-to-parallel converter with AXI4-Lite status and control
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`include "ide_regs.vh"

module ide_deserializer #(
    parameter DATA_RATE                          = `IDE_RATE_DDR,
    parameter DATA_WIDTH                         = 4,
    parameter USE_MODEL                          = `IDE_MODEL_MEMORY,
    parameter NUM_ENABLES                        = 2,
    parameter LOOPBACK_SOURCE_ENABLE             = 0,
    parameter CASCADE_ROLE                       = `IDE_ROLE_PRIMARY,
    parameter DELAY_ROUTING_SELECT               = `IDE_ROUTE_NONE,
    parameter SLOW_CLOCK_DYNAMIC_POLARITY_ENABLE = 0,
    parameter FAST_CLOCK_DYNAMIC_POLARITY_ENABLE = 0,
    parameter SLOW_CLOCK_STATIC_INVERT           = 0,
    parameter FAST_CLOCK_STATIC_INVERT           = 0,
    parameter SAMPLE1_INITIAL_VALUE              = 0,
    parameter SAMPLE2_INITIAL_VALUE              = 0,
    parameter SAMPLE3_INITIAL_VALUE              = 0,
    parameter SAMPLE4_INITIAL_VALUE              = 0,
    parameter SAMPLE1_RESET_VALUE                = 1,
    parameter SAMPLE2_RESET_VALUE                = 1,
    parameter SAMPLE3_RESET_VALUE                = 1,
    parameter SAMPLE4_RESET_VALUE                = 1
) (
    input  wire        i_mclk,
    input  wire        i_reset_n,
    input  wire [7:0]  i_axi_awaddr,
    input  wire        i_axi_awvalid,
    output wire        o_axi_awready,
    input  wire [31:0] i_axi_wdata,
    input  wire [3:0]  i_axi_wstrb,
    input  wire        i_axi_wvalid,
    output wire        o_axi_wready,
    output reg  [1:0]  o_axi_bresp,
    output reg         o_axi_bvalid,
    input  wire        i_axi_bready,
    input  wire [7:0]  i_axi_araddr,
    input  wire        i_axi_arvalid,
    output wire        o_axi_arready,
    output reg  [31:0] o_axi_rdata,
    output reg  [1:0]  o_axi_rresp,
    output reg         o_axi_rvalid,
    input  wire        i_axi_rready,
    input  wire [1:0]  i_pad_data,
    input  wire [1:0]  i_delayed_serial_input,
    input  wire [1:0]  i_loopback_serial_input,
    input  wire [1:0]  i_shift_in,
    input  wire        i_enable_first_half,
    input  wire        i_enable_second_half,
    output reg  [7:0]  o_parallel_outputs,
    output reg         o_word_valid,
    output wire [1:0]  o_comb_out,
    output wire [1:0]  o_shift_out
);

    // ****************************************************************
    // Derived configuration and elaboration checks
    // ****************************************************************
    localparam IS_DDR  = (DATA_RATE == `IDE_RATE_DDR);
    localparam NB      = IS_DDR ? 2 : 1;
    localparam PERIOD  = DATA_WIDTH / NB;
    localparam IS_SEC  = (CASCADE_ROLE == `IDE_ROLE_SECONDARY);
    localparam LOCAL_W = IS_SEC ? DATA_WIDTH - `IDE_LOCAL_MAX :
                         (DATA_WIDTH > `IDE_LOCAL_MAX ? `IDE_LOCAL_MAX
                                                      : DATA_WIDTH);
    localparam RATE_OK = (DATA_RATE == `IDE_RATE_SDR) ||
                         (DATA_RATE == `IDE_RATE_DDR);
    localparam DDR_W   = (DATA_WIDTH == 4) || (DATA_WIDTH == 6) ||
                         (DATA_WIDTH == 8) || (DATA_WIDTH == 10) ||
                         (DATA_WIDTH == 14);
    localparam SDR_W   = (DATA_WIDTH >= 2) && (DATA_WIDTH <= 8);
    localparam W_OK    = IS_DDR ? DDR_W : SDR_W;
    localparam MEM_ANY = (USE_MODEL == `IDE_MODEL_MEMORY) ||
                         (USE_MODEL == `IDE_MODEL_DDR3) ||
                         (USE_MODEL == `IDE_MODEL_QUAD);
    localparam MODEL_OK =
        (USE_MODEL == `IDE_MODEL_MEMORY) ? IS_DDR :
        (USE_MODEL == `IDE_MODEL_DDR3 || USE_MODEL == `IDE_MODEL_QUAD ||
         USE_MODEL == `IDE_MODEL_FOUR_PHASE) ? (IS_DDR && DATA_WIDTH == 4) :
        (USE_MODEL == `IDE_MODEL_STREAM);
    localparam CASC_OK = !(MEM_ANY && DATA_WIDTH > `IDE_LOCAL_MAX) &&
                         !(IS_SEC && DATA_WIDTH <= `IDE_LOCAL_MAX);
    localparam MISC_OK = (NUM_ENABLES == 1 || NUM_ENABLES == 2) &&
                         (CASCADE_ROLE == `IDE_ROLE_PRIMARY || IS_SEC) &&
                         (DELAY_ROUTING_SELECT >= `IDE_ROUTE_NONE) &&
                         (DELAY_ROUTING_SELECT <= `IDE_ROUTE_BOTH);
    localparam CFG_OK  = RATE_OK && W_OK && MODEL_OK && CASC_OK && MISC_OK;

    localparam [3:0] INIT_V  = {SAMPLE4_INITIAL_VALUE[0],
                                SAMPLE3_INITIAL_VALUE[0],
                                SAMPLE2_INITIAL_VALUE[0],
                                SAMPLE1_INITIAL_VALUE[0]};
    localparam [3:0] RESET_V = {SAMPLE4_RESET_VALUE[0],
                                SAMPLE3_RESET_VALUE[0],
                                SAMPLE2_RESET_VALUE[0],
                                SAMPLE1_RESET_VALUE[0]};
    localparam [7:0] LOCAL_MASK = 8'hff >> (8 - LOCAL_W);
    localparam [3:0] CFG_WIDTH  = DATA_WIDTH[3:0];
    localparam [2:0] CFG_MODEL  = USE_MODEL[2:0];
    localparam [1:0] CFG_ROUTE  = DELAY_ROUTING_SELECT[1:0];

    // Illegal settings tie an output to a constant and fail elaboration
    generate
        if (!CFG_OK) begin : g_bad_config
            ide_divider #(.PERIOD(2)) u_reject (.i_mclk(i_mclk),
                .i_reset_n(i_reset_n), .i_invert(1'b0), .o_tick(1'b0),
                .o_first_half());
        end
    endgenerate

    // ****************************************************************
    // Register file and AXI4-Lite slave
    // ****************************************************************
    reg  [1:0]  ctrl_q;
    reg  [15:0] word_cnt_q;
    reg         aw_got_q;
    reg  [7:0]  aw_addr_q;
    reg         w_got_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;
    reg  [31:0] rd_word;
    reg         rd_hit;
    wire        do_write;
    wire        do_read;
    wire        capture_en;

    assign o_axi_awready = !aw_got_q && !o_axi_bvalid;
    assign o_axi_wready  = !w_got_q && !o_axi_bvalid;
    assign o_axi_arready = !o_axi_rvalid;
    assign do_write      = aw_got_q && w_got_q && !o_axi_bvalid;
    assign do_read       = i_axi_arvalid && o_axi_arready;

    // Address and data are latched independently, in either order
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            aw_got_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_got_q   <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (i_axi_awvalid && o_axi_awready) begin
                aw_got_q  <= 1'b1;
                aw_addr_q <= i_axi_awaddr;
            end else if (do_write) begin
                aw_got_q  <= 1'b0;
            end
            if (i_axi_wvalid && o_axi_wready) begin
                w_got_q  <= 1'b1;
                w_data_q <= i_axi_wdata;
                w_strb_q <= i_axi_wstrb;
            end else if (do_write) begin
                w_got_q  <= 1'b0;
            end
        end
    end

    // Register write and write response
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ctrl_q       <= `IDE_CTRL_RESET;
            o_axi_bvalid <= 1'b0;
            o_axi_bresp  <= `IDE_RESP_OKAY;
        end else begin
            if (do_write) begin
                o_axi_bvalid <= 1'b1;
                o_axi_bresp  <= `IDE_RESP_OKAY;
                case (aw_addr_q)
                    `IDE_OFF_CTRL: begin
                        if (w_strb_q[0]) begin
                            ctrl_q <= w_data_q[1:0];
                        end
                    end
                    `IDE_OFF_STATUS, `IDE_OFF_WORD_COUNT,
                    `IDE_OFF_CONFIG: begin
                        o_axi_bresp <= `IDE_RESP_OKAY; // Read-only, ignored
                    end
                    default: begin
                        o_axi_bresp <= `IDE_RESP_SLVERR;
                    end
                endcase
            end else if (i_axi_bready) begin
                o_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read multiplexer
    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (i_axi_araddr)
            `IDE_OFF_CTRL: begin
                rd_word[1:0] = ctrl_q;
            end
            `IDE_OFF_STATUS: begin
                rd_word[7:0] = o_parallel_outputs;
                rd_word[`IDE_STAT_COMB_LSB+1:`IDE_STAT_COMB_LSB] = o_comb_out;
                rd_word[`IDE_STAT_EN_BIT] = capture_en;
            end
            `IDE_OFF_WORD_COUNT: begin
                rd_word[15:0] = word_cnt_q;
            end
            `IDE_OFF_CONFIG: begin
                rd_word[3:0] = CFG_WIDTH;
                rd_word[`IDE_CFG_RATE_BIT] = IS_DDR;
                rd_word[`IDE_CFG_MODEL_LSB+2:`IDE_CFG_MODEL_LSB] = CFG_MODEL;
                rd_word[`IDE_CFG_NUMCE_BIT] = (NUM_ENABLES == 2);
                rd_word[`IDE_CFG_LOOP_BIT] = (LOOPBACK_SOURCE_ENABLE != 0);
                rd_word[`IDE_CFG_ROLE_BIT] = IS_SEC;
                rd_word[`IDE_CFG_ROUTE_LSB+1:`IDE_CFG_ROUTE_LSB] = CFG_ROUTE;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    // Read data channel, answered one cycle after the address is taken
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_axi_rvalid <= 1'b0;
            o_axi_rdata  <= 32'h0000_0000;
            o_axi_rresp  <= `IDE_RESP_OKAY;
        end else if (do_read) begin
            o_axi_rvalid <= 1'b1;
            o_axi_rdata  <= rd_word;
            o_axi_rresp  <= rd_hit ? `IDE_RESP_OKAY : `IDE_RESP_SLVERR;
        end else if (i_axi_rready) begin
            o_axi_rvalid <= 1'b0;
        end
    end

    // ****************************************************************
    // Input selection and polarity
    // ****************************************************************
    wire       use_dly_reg;
    wire       use_dly_comb;
    wire [1:0] reg_src;
    wire [1:0] pair;
    wire       fast_inv;
    wire       slow_inv;
    wire       tick;
    wire       first_half;

    assign use_dly_comb = (DELAY_ROUTING_SELECT == `IDE_ROUTE_COMB) ||
                          (DELAY_ROUTING_SELECT == `IDE_ROUTE_BOTH);
    assign use_dly_reg  = (DELAY_ROUTING_SELECT == `IDE_ROUTE_REG) ||
                          (DELAY_ROUTING_SELECT == `IDE_ROUTE_BOTH);
    assign o_comb_out   = use_dly_comb ? i_delayed_serial_input
                                       : i_pad_data;

    // Loopback replaces the pad or delayed input on the registered path
    assign reg_src = (LOOPBACK_SOURCE_ENABLE != 0) ? i_loopback_serial_input :
                     (use_dly_reg ? i_delayed_serial_input : i_pad_data);

    // Dynamic polarity overrides any static inversion
    assign fast_inv = (FAST_CLOCK_DYNAMIC_POLARITY_ENABLE != 0) ?
                      ctrl_q[`IDE_CTRL_FAST_SEL] :
                      (FAST_CLOCK_STATIC_INVERT != 0);
    assign slow_inv = (SLOW_CLOCK_DYNAMIC_POLARITY_ENABLE != 0) ?
                      ctrl_q[`IDE_CTRL_SLOW_SEL] :
                      (SLOW_CLOCK_STATIC_INVERT != 0);

    // Inverted fast clock swaps which edge's bit counts as earlier
    assign pair = fast_inv ? {reg_src[0], reg_src[1]} : reg_src;

    ide_divider #(
        .PERIOD       (PERIOD)
    ) u_divider (
        .i_mclk       (i_mclk),
        .i_reset_n    (i_reset_n),
        .i_invert     (slow_inv),
        .o_tick       (tick),
        .o_first_half (first_half)
    );

    // Enable split over the two halves of a divided cycle
    assign capture_en = (NUM_ENABLES == 2) ?
                        (first_half ? i_enable_first_half
                                    : i_enable_second_half) :
                        i_enable_first_half;

    // ****************************************************************
    // Sample registers and shift chain
    // ****************************************************************
    reg  [3:0] samp_q;
    wire [3:0] samp_d;
    wire [3:0] samp_n;
    reg  [7:0] acc_q;
    wire [7:0] acc_d;
    wire [1:0] chain_in;

    assign samp_d = IS_DDR ? {samp_q[1:0], pair} : {samp_q[2:0], pair[1]};

    // Start-up contents of the sample registers
    initial begin
        samp_q = INIT_V;
    end

    // Per-bit next value: reset value, new sample, or hold
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_sample
            assign samp_n[gi] = !i_reset_n ? RESET_V[gi] :
                                capture_en ? samp_d[gi] : samp_q[gi];
        end
    endgenerate

    // Sample registers, one process drives all four bits
    always @(posedge i_mclk) begin
        samp_q <= samp_n;
    end

    // Secondary takes the bits the primary shifts out
    assign chain_in = IS_SEC ? i_shift_in :
                      (IS_DDR ? samp_q[3:2] : {samp_q[3], 1'b0});
    assign acc_d    = IS_DDR ? {acc_q[5:0], chain_in}
                             : {acc_q[6:0], chain_in[1]};
    assign o_shift_out = IS_DDR ? acc_q[7:6] : {acc_q[7], 1'b0};

    // Shift chain, word output and word count
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            acc_q              <= 8'h00;
            o_parallel_outputs <= 8'h00;
            o_word_valid       <= 1'b0;
            word_cnt_q         <= 16'h0000;
        end else begin
            acc_q        <= acc_d;
            o_word_valid <= tick;
            if (tick) begin
                o_parallel_outputs <= acc_d & LOCAL_MASK;
                word_cnt_q         <= word_cnt_q + 16'h0001;
            end
        end
    end

endmodule

// [sim/ide_props.sv]
// Port-level checker for the input deserializer
`include "ide_regs.vh"
module ide_props #(
    parameter DATA_RATE            = `IDE_RATE_DDR,
    parameter DATA_WIDTH           = 4,
    parameter DELAY_ROUTING_SELECT = `IDE_ROUTE_NONE,
    parameter CASCADE_ROLE         = `IDE_ROLE_PRIMARY
) (
    input wire       i_mclk,
    input wire       i_reset_n,
    input wire       i_axi_awvalid,
    input wire       o_axi_awready,
    input wire       i_axi_wvalid,
    input wire       o_axi_wready,
    input wire       o_axi_bvalid,
    input wire       i_axi_arvalid,
    input wire       o_axi_arready,
    input wire [31:0] o_axi_rdata,
    input wire       o_axi_rvalid,
    input wire       i_axi_rready,
    input wire [1:0] i_pad_data,
    input wire [1:0] i_delayed_serial_input,
    input wire [7:0] o_parallel_outputs,
    input wire       o_word_valid,
    input wire [1:0] o_comb_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam NB  = (DATA_RATE == `IDE_RATE_DDR) ? 2 : 1;
    localparam PER = DATA_WIDTH / NB;
    localparam LW  = (CASCADE_ROLE == `IDE_ROLE_SECONDARY) ? DATA_WIDTH - 8 :
                     (DATA_WIDTH > 8) ? 8 : DATA_WIDTH;
    localparam DLC = (DELAY_ROUTING_SELECT == `IDE_ROUTE_COMB) ||
                     (DELAY_ROUTING_SELECT == `IDE_ROUTE_BOTH);
    reg [7:0] gap_q;
    reg       seen_q;

    // ********************************
    // Cycles since the last word pulse
    // ********************************
    always @(posedge i_mclk) begin
        if (!i_reset_n) begin
            gap_q  <= 8'h00;
            seen_q <= 1'b0;
        end else if (o_word_valid) begin
            gap_q  <= 8'h00;
            seen_q <= 1'b1;
        end else begin
            gap_q <= gap_q + 8'h01;
        end
    end

    default clocking dcb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    a_reset_clear: assert property (disable iff (1'b0)
        !i_reset_n |=> !o_word_valid && o_parallel_outputs == 8'h00)
        else $error("Outputs not cleared by reset");
    a_word_spacing: assert property (
        o_word_valid && seen_q |-> gap_q == PER - 1)
        else $error("Word pulse spacing wrong");
    a_word_pulse: assert property (
        o_word_valid |=> !o_word_valid)
        else $error("Word pulse longer than one cycle");
    a_word_hold: assert property (
        !o_word_valid |-> $stable(o_parallel_outputs))
        else $error("Parallel word changed without a pulse");
    a_upper_zero: assert property (
        (o_parallel_outputs >> LW) == 8'h00)
        else $error("Unused parallel bits set");
    a_comb_route: assert property (
        o_comb_out == (DLC ? i_delayed_serial_input : i_pad_data))
        else $error("Combinational output from wrong source");
    a_write_refuse: assert property (
        o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
        else $error("Write accepted while response pending");
    a_write_answer: assert property (i_axi_awvalid && o_axi_awready
        && i_axi_wvalid && o_axi_wready |-> ##2 o_axi_bvalid)
        else $error("Write response late");
    a_read_answer: assert property (
        i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
        else $error("Read response late");
    a_read_stand: assert property (o_axi_rvalid && !i_axi_rready
        |=> o_axi_rvalid && $stable(o_axi_rdata))
        else $error("Read data dropped before taken");
    c_word: cover property (o_word_valid);
    c_write: cover property (o_axi_bvalid);
    c_read: cover property (o_axi_rvalid && i_axi_rready);
endmodule

bind ide_deserializer ide_props #(
    .DATA_RATE(DATA_RATE), .DATA_WIDTH(DATA_WIDTH),
    .DELAY_ROUTING_SELECT(DELAY_ROUTING_SELECT),
    .CASCADE_ROLE(CASCADE_ROLE)
) u_props (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_axi_awvalid(i_axi_awvalid), .o_axi_awready(o_axi_awready),
    .i_axi_wvalid(i_axi_wvalid), .o_axi_wready(o_axi_wready),
    .o_axi_bvalid(o_axi_bvalid), .i_axi_arvalid(i_axi_arvalid),
    .o_axi_arready(o_axi_arready), .o_axi_rdata(o_axi_rdata),
    .o_axi_rvalid(o_axi_rvalid), .i_axi_rready(i_axi_rready),
    .i_pad_data(i_pad_data),
    .i_delayed_serial_input(i_delayed_serial_input),
    .o_parallel_outputs(o_parallel_outputs),
    .o_word_valid(o_word_valid), .o_comb_out(o_comb_out)
);

// [sim/ide_serial_source.sv]
// Far-side serial source feeding pad, delayed and loopback pairs
module ide_serial_source (
    input  wire       i_mclk,
    input  wire [1:0] i_pair,
    output reg  [1:0] o_pad,
    output reg  [1:0] o_dly,
    output reg  [1:0] o_loop
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quiet lines before the first edge
    initial begin
        o_pad  = 2'b00;
        o_dly  = 2'b11;
        o_loop = 2'b11;
    end

    // Bit 1 is the earlier bit; other paths carry the inverse
    always @(posedge i_mclk) begin
        o_pad  <= i_pair;
        o_dly  <= ~i_pair;
        o_loop <= ~i_pair;
    end
endmodule

// [sim/tb_ide_deserializer.sv]
// Self-checking bench for the input deserializer
`include "ide_regs.vh"
module tb_ide_deserializer;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 1'b0;
    logic        reset_n = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        arvalid = 1'b0;
    logic        en1 = 1'b1;
    logic        en2 = 1'b1;
    logic [1:0]  pair = 2'b00;
    logic        awready, wready, bvalid, arready, rvalid, wv;
    logic [1:0]  bresp, rresp, pad, dly, loopb, comb;
    logic [31:0] rdata;
    logic [7:0]  par;
    logic [1:0]  tbl [4] = '{2'b00, 2'b11, 2'b01, 2'b10};
    int          err_count = 0;
    int          n_checks = 0;
    int          i;

    always #4 mclk = ~mclk;

    ide_serial_source u_src (.i_mclk(mclk), .i_pair(pair),
        .o_pad(pad), .o_dly(dly), .o_loop(loopb));

    ide_deserializer u_dut (
        .i_mclk(mclk), .i_reset_n(reset_n),
        .i_axi_awaddr(awaddr), .i_axi_awvalid(awvalid),
        .o_axi_awready(awready), .i_axi_wdata(wdata),
        .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid),
        .o_axi_wready(wready), .o_axi_bresp(bresp),
        .o_axi_bvalid(bvalid), .i_axi_bready(1'b1),
        .i_axi_araddr(araddr), .i_axi_arvalid(arvalid),
        .o_axi_arready(arready), .o_axi_rdata(rdata),
        .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
        .i_axi_rready(1'b1), .i_pad_data(pad),
        .i_delayed_serial_input(dly), .i_loopback_serial_input(loopb),
        .i_shift_in(2'b00), .i_enable_first_half(en1),
        .i_enable_second_half(en2), .o_parallel_outputs(par),
        .o_word_valid(wv), .o_comb_out(comb), .o_shift_out()
    );

    // ********************************
    // Shared tasks
    // ********************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Write with address and data offered together
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, input logic [1:0] er);
        logic aw, w, b;
        int   t;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        b = 1'b0;
        for (t = 0; t < 40 && !b; t++) begin
            @(negedge mclk);
            aw = awvalid && awready;
            w  = wvalid && wready;
            b  = bvalid;
            if (b) chk({30'h0, bresp}, {30'h0, er});
            @(posedge mclk);
            if (aw) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        if (!b) chk(32'h0, 32'h1);
    endtask

    // Read one word and compare data and response
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er);
        logic ok, g;
        int   t;
        araddr  <= a;
        arvalid <= 1'b1;
        ok = 1'b0;
        for (t = 0; t < 40 && !ok; t++) begin
            @(negedge mclk);
            g  = arvalid && arready;
            ok = rvalid;
            if (ok) chk(rdata, e);
            if (ok) chk({30'h0, rresp}, {30'h0, er});
            @(posedge mclk);
            if (g) arvalid <= 1'b0;
        end
        if (!ok) chk(32'h0, 32'h1);
    endtask

    // Let the stream settle, then compare word and comb output
    task automatic wchk(input logic [7:0] w, input logic [1:0] c);
        repeat (10) @(posedge mclk);
        @(negedge mclk);
        chk(par, w);
        chk(comb, c);
        @(posedge mclk);
    endtask

    task automatic conclude;
        $display("Checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ********************************
    // Test sequence
    // ********************************
    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        for (i = 0; i < 10 && !wv; i++) @(negedge mclk);
        chk(par, 32'h0f);
        @(posedge mclk);
        $display("Test reset_values done");
        rdc(`IDE_OFF_CONFIG, 32'h114, `IDE_RESP_OKAY);
        rdc(`IDE_OFF_CTRL, 32'h0, `IDE_RESP_OKAY);
        $display("Test defaults done");
        for (i = 0; i < 4; i++) begin
            pair <= tbl[i];
            wchk({4'h0, tbl[i], tbl[i]}, tbl[i]);
        end
        rdc(`IDE_OFF_STATUS, 32'h120a, `IDE_RESP_OKAY);
        $display("Test bit_order done");
        en1  <= 1'b0;
        en2  <= 1'b0;
        pair <= 2'b01;
        wchk(8'h0a, 2'b01);
        rdc(`IDE_OFF_STATUS, 32'h010a, `IDE_RESP_OKAY);
        en1 <= 1'b1;
        en2 <= 1'b1;
        wchk(8'h05, 2'b01);
        $display("Test enables done");
        axw(`IDE_OFF_CTRL, 32'h3, 4'hf, `IDE_RESP_OKAY);
        rdc(`IDE_OFF_CTRL, 32'h3, `IDE_RESP_OKAY);
        pair <= 2'b10;
        wchk(8'h0a, 2'b10);
        axw(`IDE_OFF_CONFIG, 32'h0, 4'hf, `IDE_RESP_OKAY);
        rdc(`IDE_OFF_CONFIG, 32'h114, `IDE_RESP_OKAY);
        axw(8'h10, 32'h1, 4'hf, `IDE_RESP_SLVERR);
        rdc(8'h10, 32'h0, `IDE_RESP_SLVERR);
        axw(`IDE_OFF_CTRL, 32'h0, 4'h0, `IDE_RESP_OKAY);
        rdc(`IDE_OFF_CTRL, 32'h3, `IDE_RESP_OKAY);
        $display("Test registers done");
        reset_n <= 1'b0;
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        chk(par, 32'h0);
        @(posedge mclk);
        reset_n <= 1'b1;
        rdc(`IDE_OFF_CTRL, 32'h0, `IDE_RESP_OKAY);
        $display("Test mid_reset done");
        conclude;
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        conclude;
    end
endmodule
